/* File: hw/rtc_buf.sv */
// small fifo for read bytes on their way to the shifter
`timescale 1ns/1ps
module rtc_buf #(
  parameter int unsigned DEPTH = 2
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_in,
  input  wire logic   clr_in,
  rtc_strm_if.snk     in_if,
  rtc_strm_if.src     out_if
);
  import rtc_pkg::*;
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  rtc_byte_t   mem_q [DEPTH];
  rtc_byte_t   mem_d [DEPTH];
  logic [AW:0]   cnt_q, cnt_d;
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic          push, pop;

  always_comb
  begin
    in_if.ready  = cnt_q != (AW+1)'(DEPTH);
    out_if.valid = cnt_q != '0;
    out_if.data  = mem_q[rp_q];
    push = in_if.valid & in_if.ready;
    pop  = out_if.valid & out_if.ready;
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    if (push)
    begin
      mem_d[wp_q] = in_if.data;
      wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
    end
    if (pop)
      rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (clr_in)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      mem_q <= '{default: '0};
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: hw/rtc_core.sv */
// clock/calendar core with serial register port and supply monitor
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_core #(
  parameter bit          SEL_HIGH       = 1'b0,
  parameter int unsigned RST_TICKS      = `MS_TO_TICKS(`RST_DLY_MS),
  parameter int unsigned START_TICKS    = `MS_TO_TICKS(`OSC_START_MS),
  parameter int unsigned DEBOUNCE_TICKS = `MS_TO_TICKS(`DEBOUNCE_MS)
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic sel_in,
  input  wire logic sclk_in,
  input  wire logic sdi_in,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  input  wire logic vcc_ok_in,
  input  wire logic vcc_above_backup_in,
  output logic      backup_supply_out,
  input  wire logic rst_pin_in,
  output logic      rst_pin_out,
  output logic      rst_pin_oe_out,
  output logic      irq_pin_out,
  output logic      irq_pin_oe_out,
  output logic      wave_or_irq_out,
  output logic      wave_or_irq_oe_out,
  output logic      square_wave_out,
  output logic      square_wave_oe_out
);
  import rtc_pkg::*;

  function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic rtc_byte_t last_date(input logic [4:0] m,
                                          input rtc_byte_t y);
    logic leap;
    leap = y[4] ? (y[1:0] == 2'b10 && !y[3]) : (y[1:0] == 2'b00);
    if (m == `MON_FEB)
      last_date = leap ? `DAYS_LEAP : `DAYS_FEB;
    else if (m == `MON_APR || m == `MON_JUN ||
             m == `MON_SEP || m == `MON_NOV)
      last_date = `DAYS_SHORT;
    else
      last_date = `DAYS_LONG;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  rtc_byte_t   rg_q [16];
  rtc_byte_t   rg_d [16];
  rtc_byte_t   snap_q [8];
  rtc_byte_t   snap_d [8];
  rtc_byte_t   wbuf_q [8];
  rtc_byte_t   wbuf_d [8];
  logic [7:0]  wpend_q, wpend_d;
  logic [25:0] acc_q, acc_d;
  logic [26:0] acc_sum;
  logic        ph_q, ph_d;
  logic [14:0] oc_q, oc_d, ha_q, ha_d;
  logic [15:0] ha_sum;
  logic        half_tick, osc_raw, osc_tick, hs_tick, osc_off;
  rtc_st_e     st_q, st_d;
  logic [2:0]  bit_q, bit_d;
  logic [7:0]  sh_q, sh_d, osh_q, osh_d;
  logic [3:0]  ptr_q, ptr_d, fptr_q, fptr_d;
  logic        sel_q, sclk_q, sdo_q, sdo_d, oe_q, oe_d;
  logic        sel_act, sel_rise, sel_fall, sck_rise, sck_fall;
  logic        done, wr_stb, load_now, access_ok, rst_drive;
  rtc_byte_t   byte_in;
  logic        cy, alm_hit, sq_lvl, irq_act, wave_en;
  rtc_byte_t   hr, nx;
  logic        bak_q, irq_oe_q, woi_oe_q, sqw_oe_q;
  rtc_strm_if  fetch_if();
  rtc_strm_if  out_if();

  assign osc_off = rg_q[`REG_CTRL][`CTL_OSC_OFF];
  assign wave_en = rg_q[`REG_CTRL][`CTL_WAVE_EN];

  // ---------------------------------------------------------------
  // oscillator model and hundredths divider
  // ---------------------------------------------------------------
  // fractional accumulators keep the average rates exact
  always_comb
  begin
    acc_sum   = {1'b0, acc_q} + 27'(2 * `OSC_HZ);
    half_tick = acc_sum >= 27'(`SYS_HZ);
    acc_d     = half_tick ? 26'(acc_sum - 27'(`SYS_HZ)) : acc_sum[25:0];
    ph_d      = ph_q ^ half_tick;
    osc_raw   = half_tick & ph_q;
    osc_tick  = osc_raw & ~osc_off; // [RULE21]
    oc_d      = oc_q + 15'(osc_tick);
    ha_sum    = {1'b0, ha_q}
              + (osc_tick ? 16'(`HS_PER_SEC) : 16'h0000);
    hs_tick   = ha_sum[15]; // [RULE25]
    ha_d      = ha_sum[14:0];
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      acc_q <= '0;
      ph_q  <= 1'b0;
      oc_q  <= '0;
      ha_q  <= '0;
    end
    else
    begin
      acc_q <= acc_d;
      ph_q  <= ph_d;
      oc_q  <= oc_d;
      ha_q  <= ha_d;
    end
  end

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  // samples on sclk rising, shifts out on sclk falling
  always_comb
  begin
    access_ok = vcc_ok_in & ~rst_drive; // [RULE17] [RULE18]
    sel_act  = (SEL_HIGH ? sel_in : ~sel_in) & access_ok;
    sel_rise = sel_act & ~sel_q;
    sel_fall = ~sel_act & sel_q;
    sck_rise = sel_act & sclk_in & ~sclk_q; // [RULE10]
    sck_fall = sel_act & ~sclk_in & sclk_q;
    byte_in  = {sh_q[6:0], sdi_in};
    done     = sck_rise & (bit_q == 3'd7);
    st_d     = st_q;
    bit_d    = bit_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    fptr_d   = fptr_q;
    osh_d    = osh_q;
    sdo_d    = sdo_q;
    oe_d     = oe_q;
    snap_d   = snap_q;
    wbuf_d   = wbuf_q;
    wpend_d  = wpend_q;
    wr_stb   = 1'b0;
    load_now = 1'b0;
    out_if.ready   = 1'b0;
    fetch_if.valid = st_q == st_read;
    fetch_if.data  = fptr_q[3] ? rg_q[fptr_q] : snap_q[fptr_q[2:0]];
    if (fetch_if.valid & fetch_if.ready)
      fptr_d = fptr_q + 4'h1; // [RULE23]
    if (sck_rise)
    begin
      bit_d = bit_q + 3'd1;
      sh_d  = byte_in;
    end
    case (st_q)
      st_idle:
        if (sel_rise)
        begin
          st_d  = st_addr;
          bit_d = 3'd0;
          for (int i = 0; i < 8; i++)
            snap_d[i] = rg_q[i]; // [RULE24]
        end
      st_addr:
        if (done)
        begin
          ptr_d  = byte_in[3:0]; // [RULE8] [RULE22]
          fptr_d = byte_in[3:0];
          st_d   = byte_in[`ADDR_WR_BIT] ? st_write : st_read;
          oe_d   = ~byte_in[`ADDR_WR_BIT]; // [RULE9] [RULE12]
        end
      st_write:
        if (done)
        begin
          ptr_d = ptr_q + 4'h1; // [RULE11] [RULE23]
          if (ptr_q[3])
            wr_stb = 1'b1;
          else
          begin
            wbuf_d[ptr_q[2:0]]  = byte_in; // [RULE27]
            wpend_d[ptr_q[2:0]] = 1'b1;
          end
        end
      st_read:
        if (sck_fall)
        begin
          if (bit_q == 3'd0)
          begin
            // an empty buffer here shifts out zeros
            out_if.ready = 1'b1; // [RULE11]
            sdo_d = out_if.valid & out_if.data[7];
            osh_d = out_if.valid ? {out_if.data[6:0], 1'b0} : 8'h00;
          end
          else
          begin
            sdo_d = osh_q[7];
            osh_d = {osh_q[6:0], 1'b0};
          end
        end
    endcase
    if (sel_fall)
    begin
      st_d     = st_idle;
      oe_d     = 1'b0; // [RULE9]
      wpend_d  = '0;
      load_now = access_ok; // [RULE27]
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_q    <= st_idle;
      bit_q   <= '0;
      sh_q    <= '0;
      osh_q   <= '0;
      ptr_q   <= '0;
      fptr_q  <= '0;
      sel_q   <= 1'b0;
      sclk_q  <= 1'b0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      snap_q  <= '{default: '0};
      wbuf_q  <= '{default: '0};
      wpend_q <= '0;
    end
    else
    begin
      st_q    <= st_d;
      bit_q   <= bit_d;
      sh_q    <= sh_d;
      osh_q   <= osh_d;
      ptr_q   <= ptr_d;
      fptr_q  <= fptr_d;
      sel_q   <= sel_act;
      sclk_q  <= sclk_in;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      snap_q  <= snap_d;
      wbuf_q  <= wbuf_d;
      wpend_q <= wpend_d;
    end
  end

  rtc_buf #(
    .DEPTH (`BUF_DEPTH)
  ) u_buf (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .clr_in     (st_q != st_read),
    .in_if      (fetch_if),
    .out_if     (out_if)
  );

  // ---------------------------------------------------------------
  // timekeeping, alarm and register file
  // ---------------------------------------------------------------
  // supply state never gates counting [RULE20]
  always_comb
  begin
    rg_d = rg_q;
    nx   = 8'h00;
    hr   = rg_q[3];
    cy   = hs_tick; // [RULE13]
    if (cy)
    begin
      cy = rg_q[0] == `HSEC_MAX;
      rg_d[0] = cy ? 8'h00 : bcd_inc(rg_q[0]);
    end
    for (int i = 1; i < 3; i++)
      if (cy)
      begin
        cy = rg_q[i] == `MINSEC_MAX;
        rg_d[i] = cy ? 8'h00 : bcd_inc(rg_q[i]);
      end
    if (cy)
    begin
      if (hr[`HR_12H_BIT]) // [RULE15]
      begin
        if (hr[4:0] == `HR12_MAX)
        begin
          rg_d[3] = {hr[7:5], `HR12_MIN};
          cy = 1'b0;
        end
        else if (hr[4:0] == `HR12_PRE)
        begin
          rg_d[3] = {hr[7:6], ~hr[`HR_PM_BIT], `HR12_MAX};
          cy = hr[`HR_PM_BIT];
        end
        else
        begin
          nx = bcd_inc({3'b000, hr[4:0]});
          rg_d[3] = {hr[7:5], nx[4:0]};
          cy = 1'b0;
        end
      end
      else
      begin
        cy = {2'b00, hr[5:0]} == `HR24_MAX;
        nx = cy ? 8'h00 : bcd_inc({2'b00, hr[5:0]});
        rg_d[3] = {hr[7:6], nx[5:0]};
      end
    end
    if (cy)
    begin
      rg_d[4] = (rg_q[4] == `DOW_MAX) ? `DAY_MIN : bcd_inc(rg_q[4]);
      cy = rg_q[5] == last_date(rg_q[6][4:0], rg_q[7]); // [RULE14]
      rg_d[5] = cy ? `DAY_MIN : bcd_inc(rg_q[5]);
    end
    if (cy)
    begin
      cy = rg_q[6][4:0] == `MON_MAX;
      nx = cy ? `DAY_MIN : bcd_inc({3'b000, rg_q[6][4:0]});
      rg_d[6] = {rg_q[6][7:5], nx[4:0]};
    end
    if (cy)
    begin
      cy = rg_q[7] == `YEAR_MAX;
      rg_d[7] = cy ? 8'h00 : bcd_inc(rg_q[7]);
      rg_d[6][7] = rg_d[6][7] ^ cy;
    end
    alm_hit = hs_tick & (rg_d[0] == rg_q[8]) // [RULE16]
      & (rg_q[9][`ALM_MASK_BIT]  | rg_d[1][6:0] == rg_q[9][6:0])
      & (rg_q[10][`ALM_MASK_BIT] | rg_d[2][6:0] == rg_q[10][6:0])
      & (rg_q[11][`ALM_MASK_BIT] | rg_d[3][6:0] == rg_q[11][6:0])
      & (rg_q[12][`ALM_MASK_BIT] | (rg_q[12][`ALM_DAY_BIT]
          ? rg_d[4][2:0] == rg_q[12][2:0]
          : rg_d[5][5:0] == rg_q[12][5:0]));
    // a pending load overrides a tick in the same cycle
    if (load_now)
      for (int i = 0; i < 8; i++)
        if (wpend_q[i])
          rg_d[i] = wbuf_q[i]; // [RULE27]
    if (wr_stb)
    begin
      if (ptr_q == `REG_CTRL)
        rg_d[ptr_q] = byte_in & `CTL_WR_MASK;
      else if (ptr_q == `REG_STATUS)
        rg_d[ptr_q] = rg_q[ptr_q] & (byte_in | ~`STS_CLR_MASK);
      else
        rg_d[ptr_q] = byte_in;
    end
    // flag sets come last so they beat a clear
    if (alm_hit)
      rg_d[`REG_STATUS][`STS_AF] = 1'b1;
    if (osc_off)
      rg_d[`REG_STATUS][`STS_OSF] = 1'b1;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 8; i++)
        rg_q[i] <= 8'(`TIME_RESET >> (8 * i));
      for (int i = 8; i < 16; i++)
        rg_q[i] <= 8'h00;
      rg_q[`REG_CTRL]   <= `CTL_RESET;
      rg_q[`REG_STATUS] <= `STS_RESET;
    end
    else
      rg_q <= rg_d;
  end

  // ---------------------------------------------------------------
  // supply, reset pin and output pins
  // ---------------------------------------------------------------
  rtc_pwr #(
    .RST_TICKS      (RST_TICKS),
    .START_TICKS    (START_TICKS),
    .DEBOUNCE_TICKS (DEBOUNCE_TICKS)
  ) u_pwr (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tick_in    (osc_raw),
    .vcc_ok_in  (vcc_ok_in),
    .osc_off_in (osc_off),
    .pin_in     (rst_pin_in),
    .drive_out  (rst_drive)
  );

  always_comb
  begin
    case (rg_q[`REG_CTRL][`CTL_RS_LO +: 2])
      2'd0:    sq_lvl = oc_q[14];
      2'd1:    sq_lvl = oc_q[2];
      2'd2:    sq_lvl = oc_q[1];
      default: sq_lvl = ph_q;
    endcase
    if (osc_off)
      sq_lvl = 1'b1;
    irq_act = rg_q[`REG_CTRL][`CTL_AIE]
            & rg_q[`REG_STATUS][`STS_AF]; // [RULE5]
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      bak_q    <= 1'b0;
      irq_oe_q <= 1'b0;
      woi_oe_q <= 1'b0;
      sqw_oe_q <= 1'b0;
    end
    else
    begin
      bak_q    <= ~vcc_ok_in & ~vcc_above_backup_in; // [RULE19]
      irq_oe_q <= irq_act; // [RULE5]
      woi_oe_q <= wave_en ? ~sq_lvl : irq_act; // [RULE6]
      sqw_oe_q <= wave_en & ~sq_lvl; // [RULE7]
    end
  end

  assign sdo_out            = sdo_q;
  assign sdo_oe_out         = oe_q;
  assign backup_supply_out  = bak_q;
  assign rst_pin_out        = 1'b0;
  assign rst_pin_oe_out     = rst_drive;
  assign irq_pin_out        = 1'b0;
  assign irq_pin_oe_out     = irq_oe_q;
  assign wave_or_irq_out    = 1'b0;
  assign wave_or_irq_oe_out = woi_oe_q;
  assign square_wave_out    = 1'b0;
  assign square_wave_oe_out = sqw_oe_q;
endmodule

/* File: hw/rtc_params.svh */
// constants for the serial clock/calendar core
//
// Contract
// RULE1: reset pin low while primary supply fails
// RULE2: release reset after release delay above threshold
// RULE3: debounced pushbutton on reset pin asserts reset
// RULE4: oscillator off adds startup time to delay
// RULE5: interrupt pin only when enabled, any supply
// RULE6: wave enable selects square wave, else interrupt
// RULE7: square wave output runs on either supply
// RULE8: master shifts address then data bytes in
// RULE9: serial output driven only during reads
// RULE10: master selects, then clocks every bit
// RULE11: any number of bytes per select
// RULE12: shared data line driven by each phase owner
// RULE13: counters hundredths to year with carries
// RULE14: month end and leap year rollover
// RULE15: 12 or 24 hour format with pm
// RULE16: alarm compares every field to hundredths
// RULE17: no register access below fail threshold
// RULE18: no access until reset pin released
// RULE19: backup supply below threshold and backup level
// RULE20: keep counting and contents on backup
// RULE21: timekeeping derived from oscillator clock
// RULE22: read 00h-0Fh, write with address msb
// RULE23: pointer increments per byte, wraps
// RULE24: select copies time into read snapshot
// RULE25: hundredths advance every 10 ms
// RULE26: pushbutton low for debounce, then delay
// RULE27: time writes load counters at access end
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define SYS_HZ        50000000
`define OSC_HZ        32768
`define HS_PER_SEC    100
`define RST_DLY_MS    250
`define OSC_START_MS  1000
`define DEBOUNCE_MS   10
`define MS_TO_TICKS(ms) (((ms) * `OSC_HZ + 999) / 1000)
`define BUF_DEPTH     2
`define REG_CTRL      4'hD
`define REG_STATUS    4'hE
`define ADDR_WR_BIT   7
`define HR_12H_BIT    6
`define HR_PM_BIT     5
`define ALM_MASK_BIT  7
`define ALM_DAY_BIT   6
`define CTL_OSC_OFF   7
`define CTL_RS_LO     3
`define CTL_WAVE_EN   2
`define CTL_AIE       0
`define STS_OSF       7
`define STS_AF        0
`define CTL_RESET     8'h00
`define STS_RESET     8'h80
`define CTL_WR_MASK   8'hBD
`define STS_CLR_MASK  8'h81
`define TIME_RESET    64'h0001010100000000
`define HSEC_MAX      8'h99
`define MINSEC_MAX    8'h59
`define HR24_MAX      8'h23
`define HR12_MAX      5'h12
`define HR12_PRE      5'h11
`define HR12_MIN      5'h01
`define DOW_MAX       8'h07
`define DAY_MIN       8'h01
`define MON_MAX       5'h12
`define MON_FEB       5'h02
`define MON_APR       5'h04
`define MON_JUN       5'h06
`define MON_SEP       5'h09
`define MON_NOV       5'h11
`define YEAR_MAX      8'h99
`define DAYS_FEB      8'h28
`define DAYS_LEAP     8'h29
`define DAYS_SHORT    8'h30
`define DAYS_LONG     8'h31
`endif

/* File: hw/rtc_pkg.sv */
// shared types for the clock/calendar core
package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_addr  = 2'b01,
    st_write = 2'b11,
    st_read  = 2'b10
  } rtc_st_e;
endpackage

/* File: hw/rtc_pwr.sv */
// reset pin supervisor: supply fail, release delay, pushbutton
`timescale 1ns/1ps
module rtc_pwr #(
  parameter int unsigned RST_TICKS      = 8192,
  parameter int unsigned START_TICKS    = 32768,
  parameter int unsigned DEBOUNCE_TICKS = 328,
  parameter int unsigned CNT_W          = 17
) (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic tick_in,
  input  wire logic vcc_ok_in,
  input  wire logic osc_off_in,
  input  wire logic pin_in,
  output logic      drive_out
);
  logic [CNT_W-1:0] dly_q, dly_d, db_q, db_d, lim;
  logic             drv_q, drv_d;

  always_comb
  begin
    lim = CNT_W'(RST_TICKS)
        + (osc_off_in ? CNT_W'(START_TICKS) : '0); // [RULE4]
    dly_d = dly_q;
    db_d  = db_q;
    drv_d = drv_q;
    if (!vcc_ok_in)
    begin
      drv_d = 1'b1; // [RULE1]
      dly_d = '0;
      db_d  = '0;
    end
    else if (drv_q)
    begin
      if (tick_in)
      begin
        dly_d = dly_q + CNT_W'(1);
        if (dly_d >= lim)
          drv_d = 1'b0; // [RULE2]
      end
    end
    // our own drive reads back low, so only look while released
    else if (pin_in)
      db_d = '0;
    else if (tick_in)
    begin
      db_d = db_q + CNT_W'(1);
      if (db_d >= CNT_W'(DEBOUNCE_TICKS))
      begin
        drv_d = 1'b1; // [RULE3] [RULE26]
        dly_d = '0;
        db_d  = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      dly_q <= '0;
      db_q  <= '0;
      drv_q <= 1'b1;
    end
    else
    begin
      dly_q <= dly_d;
      db_q  <= db_d;
      drv_q <= drv_d;
    end
  end

  assign drive_out = drv_q;
endmodule

/* File: hw/rtc_strm_if.sv */
// byte stream with valid and ready between core parts
`timescale 1ns/1ps
interface rtc_strm_if;
  rtc_pkg::rtc_byte_t data;
  logic               valid;
  logic               ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: testbench/rtc_core_chk.sv */
// port assertions for the clock core
`timescale 1ns/1ps
module rtc_core_chk #(
  parameter bit          SEL_HIGH       = 1'b0,
  parameter int unsigned RST_TICKS      = 8192,
  parameter int unsigned DEBOUNCE_TICKS = 328
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sel_in,
  input wire logic sclk_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic vcc_ok_in,
  input wire logic vcc_above_backup_in,
  input wire logic backup_supply_out,
  input wire logic rst_pin_in,
  input wire logic rst_pin_oe_out,
  input wire logic wave_or_irq_oe_out,
  input wire logic square_wave_oe_out
);
  int unsigned rc_q;
  int unsigned bc_q;
  // one oscillator tick is about 1526 cycles; bounds keep margin
  always_ff @(posedge sys_clk_in)
  begin
    rc_q <= (rst_pin_oe_out && vcc_ok_in) ? rc_q + 1 : 0;
    bc_q <= (!rst_pin_in && !rst_pin_oe_out) ? bc_q + 1 : 0;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ----
  // assertions
  // ----
  a_fail_drive: assert property (
    !vcc_ok_in |-> ##[1:2] rst_pin_oe_out)
    else $error("reset pin not driven on supply fail");
  a_release_min: assert property ($fell(rst_pin_oe_out)
    |-> rc_q > (RST_TICKS - 1) * 1450) else $error("reset released early");
  a_release_max: assert property (rst_pin_oe_out
    |-> rc_q < (RST_TICKS + 1) * 1600) else $error("reset held too long");
  a_btn_min: assert property ($rose(rst_pin_oe_out) && vcc_ok_in
    |-> bc_q > (DEBOUNCE_TICKS - 1) * 1450) else $error("button too fast");
  a_btn_max: assert property (!rst_pin_oe_out
    |-> bc_q < (DEBOUNCE_TICKS + 2) * 1600) else $error("button ignored");
  a_fail_port: assert property (!vcc_ok_in [*3] |-> !sdo_oe_out)
    else $error("data driven during supply fail");
  a_rst_port: assert property (rst_pin_oe_out [*3] |-> !sdo_oe_out)
    else $error("data driven while reset pin low");
  a_sdo_sel: assert property (
    (sel_in != SEL_HIGH) [*3] |-> !sdo_oe_out)
    else $error("data driven while deselected");
  a_sdo_fall: assert property (sdo_oe_out && $past(sdo_oe_out)
    && sel_in == SEL_HIGH && $past(sel_in) == SEL_HIGH && $changed(sdo_out)
    |-> !sclk_in) else $error("data changed with serial clock high");
  a_wave_pair: assert property (
    square_wave_oe_out |-> wave_or_irq_oe_out)
    else $error("combined pin disagrees with wave");
  a_backup_sel: assert property (1'b1
    |=> backup_supply_out == $past(!vcc_ok_in && !vcc_above_backup_in))
    else $error("wrong supply selected");
endmodule
bind rtc_core rtc_core_chk #(
  .SEL_HIGH      (SEL_HIGH),
  .RST_TICKS     (RST_TICKS),
  .DEBOUNCE_TICKS(DEBOUNCE_TICKS)
) chk (
  .sys_clk_in         (sys_clk_in),
  .rst_in             (rst_in),
  .sel_in             (sel_in),
  .sclk_in            (sclk_in),
  .sdo_out            (sdo_out),
  .sdo_oe_out         (sdo_oe_out),
  .vcc_ok_in          (vcc_ok_in),
  .vcc_above_backup_in(vcc_above_backup_in),
  .backup_supply_out  (backup_supply_out),
  .rst_pin_in         (rst_pin_in),
  .rst_pin_oe_out     (rst_pin_oe_out),
  .wave_or_irq_oe_out (wave_or_irq_oe_out),
  .square_wave_oe_out (square_wave_oe_out)
);

/* File: testbench/rtc_master.sv */
// serial master model for the four-wire register port
`timescale 1ns/1ps
module rtc_master (
  input  wire logic sys_clk_in,
  input  wire logic sdo_in,
  output logic      sel_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  import rtc_pkg::*;
  rtc_byte_t wr_data [16];
  rtc_byte_t rd_data [16];
  initial
  begin
    sel_n_out = 1'b1;
    sclk_out  = 1'b1;
    sdi_out   = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge sys_clk_in);
  endtask
  // ----
  // one access: address byte, then n data bytes
  // ----
  task automatic xfer(input rtc_byte_t addr, input int n);
    rtc_byte_t sh;
    logic      rd;
    rd = !addr[7];
    @(posedge sys_clk_in);
    sel_n_out <= 1'b0;
    half();
    for (int b = 0; b <= n; b++)
    begin
      sh = (b == 0) ? addr : wr_data[b-1];
      for (int i = 7; i >= 0; i--)
      begin
        sclk_out <= 1'b0;
        // unused input toggles so a stale bit cannot pass for data
        sdi_out <= (b > 0 && rd) ? !sdi_out : sh[i];
        half();
        if (b > 0)
          rd_data[b-1][i] = sdo_in;
        sclk_out <= 1'b1;
        half();
      end
    end
    sel_n_out <= 1'b1;
    half();
  endtask
endmodule

/* File: testbench/tb_rtc_core.sv */
// self-checking bench for the clock core
`timescale 1ns/1ps
module tb_rtc_core;
  import rtc_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in     = 1'b1;
  logic vcc_ok     = 1'b1;
  logic vcc_hi     = 1'b1;
  logic btn        = 1'b0;
  logic sel_n;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic backup;
  logic rst_oe;
  logic wave_oe;
  logic sq_oe;
  logic irq_oe;
  logic pin;
  int   errors = 0;
  int   checks = 0;
  always #10 sys_clk_in = !sys_clk_in;
  // open-drain pin with pull-up, pulled by device or button
  assign pin = !(rst_oe || btn);
  rtc_core #(.RST_TICKS(4), .START_TICKS(4), .DEBOUNCE_TICKS(3)) uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .sel_in(sel_n),
    .sclk_in(sclk), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .vcc_ok_in(vcc_ok), .vcc_above_backup_in(vcc_hi),
    .backup_supply_out(backup), .rst_pin_in(pin), .rst_pin_out(),
    .rst_pin_oe_out(rst_oe), .irq_pin_out(), .irq_pin_oe_out(irq_oe),
    .wave_or_irq_out(), .wave_or_irq_oe_out(wave_oe),
    .square_wave_out(), .square_wave_oe_out(sq_oe));
  rtc_master mst (.sys_clk_in(sys_clk_in), .sdo_in(sdo),
    .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi));
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_pin(input logic lvl, input int bound);
    int n;
    n = 0;
    while (rst_oe !== lvl && n < bound)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    check("reset_pin", {7'h0, lvl}, {7'h0, rst_oe});
    if (rst_oe !== lvl)
      results();
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    mst.wr_data[0] = 8'h00;
    mst.wr_data[1] = 8'hA5;
    mst.xfer(8'h8E, 2);
    mst.wr_data[1] = 8'h30;
    mst.xfer(8'h80, 2);
    mst.xfer(8'h0E, 4);
    check("status", 8'h00, mst.rd_data[0]);
    check("storage", 8'hA5, mst.rd_data[1]);
    check("wrap", 8'h00, mst.rd_data[2]);
    check("seconds", 8'h30, mst.rd_data[3]);
  endtask
  task automatic t_wave();
    int   rises;
    int   diffs;
    logic prev;
    mst.wr_data[0] = 8'h1C;
    mst.xfer(8'h8D, 1);
    vcc_ok <= 1'b0;
    vcc_hi <= 1'b0;
    mst.wr_data[0] = 8'h5A;
    mst.xfer(8'h8F, 1);
    rises = 0;
    diffs = 0;
    prev = sq_oe;
    repeat (4000)
    begin
      @(negedge sys_clk_in);
      rises += (sq_oe && !prev) ? 1 : 0;
      diffs += (wave_oe !== sq_oe) ? 1 : 0;
      prev = sq_oe;
    end
    check("wave_runs", 8'h01, {7'h0, rises >= 2});
    check("wave_pin", 8'h00, {7'h0, diffs != 0});
    check("backup", 8'h01, {7'h0, backup});
    check("fail_pin", 8'h01, {7'h0, rst_oe});
    @(posedge sys_clk_in);
    vcc_hi <= 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check("primary", 8'h00, {7'h0, backup});
    @(posedge sys_clk_in);
    vcc_ok <= 1'b1;
    wait_pin(1'b0, 20000);
    mst.xfer(8'h0D, 3);
    check("control", 8'h1C, mst.rd_data[0]);
    check("blocked", 8'hA5, mst.rd_data[2]);
    mst.wr_data[0] = 8'h00;
    mst.xfer(8'h8D, 1);
    repeat (2) @(negedge sys_clk_in);
    check("wave_off", 8'h00, {7'h0, sq_oe});
    check("irq_mode", 8'h00, {7'h0, wave_oe});
    check("irq_pin", 8'h00, {7'h0, irq_oe});
  endtask
  task automatic t_button();
    @(posedge sys_clk_in);
    btn <= 1'b1;
    repeat (2000) @(posedge sys_clk_in);
    btn <= 1'b0;
    @(negedge sys_clk_in);
    check("bounce", 8'h00, {7'h0, rst_oe});
    @(posedge sys_clk_in);
    btn <= 1'b1;
    wait_pin(1'b1, 12000);
    @(posedge sys_clk_in);
    btn <= 1'b0;
    mst.wr_data[0] = 8'h3C;
    mst.xfer(8'h8F, 1);
    wait_pin(1'b0, 20000);
    mst.xfer(8'h0F, 1);
    check("held_off", 8'hA5, mst.rd_data[0]);
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    wait_pin(1'b0, 20000);
    t_regs();
    t_wave();
    t_button();
    results();
  end
endmodule
